// ==== sls_cfg.svh ====
// sls_cfg.svh: register offsets, field positions and reset values of the line setup engine
`ifndef SLS_CFG_SVH
`define SLS_CFG_SVH
`define SLS_ADDR_W 8
`define SLS_OFF_SLOPE_DRAW 8'h00
`define SLS_OFF_SLOPE_SETUP 8'h20
`define SLS_OFF_DRAW_ADDR 8'h40
`define SLS_OFF_PATTERN 8'h44
`define SLS_OFF_CONTINUE 8'h48
`define SLS_OFF_PITCH 8'h4C
`define SLS_OFF_MODE 8'h50
`define SLS_OFF_ROP 8'h54
`define SLS_OFF_FG 8'h58
`define SLS_OFF_BG 8'h5C
`define SLS_OFF_PARAM1 8'h60
`define SLS_OFF_PARAM2 8'h64
`define SLS_OFF_PARAM3 8'h68
`define SLS_OFF_STATUS 8'h6C
`define SLS_OFF_WORK_ADDR 8'h70
`define SLS_OFF_WORK_ERR 8'h74
`define SLS_MODE_CAP_BIT 15
`define SLS_MODE_STRICT_BIT 4
`define SLS_MODE_PIXSZ_LO 0
`define SLS_MODE_RESET 32'h0000_0000
`define SLS_ROP_RESET 32'h000F_0003
`define SLS_SEG_FULL 5'h10
`define SLS_RESP_OKAY 2'h0
`define SLS_RESP_SLVERR 2'h2
`endif

// ==== sls_engine.sv ====
// sls_engine.sv: line setup, segment chaining and pixel stepping behind an AXI4-Lite slave
// Functional notes
// [R1] draw slope write computes terms, starts segment
// [R2] slope word: rise high half, run low
// [R3] start address and pattern come from registers
// [R4] run major when run at least rise
// [R5] major step pixel size or pitch
// [R6] bias bit depends on environment
// [R7] length is major plus cap, mod 16
// [R8] error increments are minor and major minus minor
// [R9] initial error from doubled minor, halved
// [R10] address step one, negated if major zero
// [R11] address step two adds minor step
// [R12] computed terms land in readable parameter registers
// [R13] software never writes zero rise and run
// [R14] setup slope write loads terms, no drawing
// [R15] working error, length, address; start on trigger
// [R16] reload length and error after slope write
// [R17] reload address only after address write
// [R18] segment end: next pixel, length 16
// [R19] continue write extends line sixteen pixels
// [R20] colours and operation sampled at each start
// [R21] slope without address keeps working address
// [R22] cap flag clear skips last pixel
// [R23] pattern one foreground, zero background
// [R24] raster operation and mask go with pixel
// [R25] error sign chooses step pair
// [R26] decrement length, stop at zero
// [R27] hold off writes while a segment runs
`include "sls_cfg.svh"
module sls_engine (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [31:0] pix_addr,
  output logic [31:0] pix_colour,
  output logic [3:0] pix_rop,
  output logic [3:0] pix_byte_mask,
  output logic [2:0] pix_bitmap,
  output logic busy
);
  // byte-lane merge for ordinary registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : merge

  // true when the word address falls in one of the eight-entry slope banks
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a[7:5] == base[7:5]);
  endfunction : in_bank

  logic aw_held;
  logic [7:0] aw_addr_q;
  logic w_held;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic wr_draw, wr_setup, wr_addr, wr_cont, wr_ok;
  logic [31:0] draw_address_reg, pattern_data_reg, bitmap_pitch_reg, draw_mode_reg;
  logic [31:0] raster_operation_reg, foreground_colour_reg, background_colour_reg;
  logic [31:0] stepper_param_one_reg, stepper_param_two_reg, stepper_param_three_reg;
  logic [31:0] read_mux;
  logic [7:0] raddr;
  logic read_ok;
  logic slope_dirty;
  logic addr_dirty;
  logic start_pend;
  logic [15:0] start_pattern;
  sls_pkg::sls_state_e state;
  logic [31:0] w_addr;
  logic [15:0] w_err;
  logic [4:0] w_len;
  logic [15:0] w_pattern;
  logic [31:0] s_fg;
  logic [31:0] s_bg;
  logic [4:0] next_len;
  logic [15:0] next_err;
  logic [31:0] next_addr;
  logic [31:0] step_addr;
  logic [15:0] step_err;
  logic step;
  logic [15:0] pixel_bytes;
  logic [15:0] su_ai1, su_ei1, su_ai2, su_ei2, su_ierr;
  logic [3:0] su_len;

  // pixel size code: 0 is one byte, 1 two bytes, otherwise four
  always_comb begin
    case (draw_mode_reg[`SLS_MODE_PIXSZ_LO +: 2])
      2'h0: pixel_bytes = 16'h0001;
      2'h1: pixel_bytes = 16'h0002;
      default: pixel_bytes = 16'h0004;
    endcase
  end

  // setup arithmetic on the slope word being written
  sls_setup u_setup (
    .rise(w_data_q[31:16]), // [R2]
    .run(w_data_q[15:0]), // [R2]
    .pixel_bytes(pixel_bytes),
    .pitch(bitmap_pitch_reg[15:0]),
    .cap_ends(draw_mode_reg[`SLS_MODE_CAP_BIT]), // [R22]
    .strict_env(draw_mode_reg[`SLS_MODE_STRICT_BIT]),
    .addr_inc_one(su_ai1),
    .err_inc_one(su_ei1),
    .addr_inc_two(su_ai2),
    .err_inc_two(su_ei2),
    .init_err(su_ierr),
    .seg_len(su_len)
  );

  // writes stall while a segment is pending or drawing so the working set stays coherent
  assign busy = start_pend | (state != sls_pkg::sls_idle);
  assign do_write = aw_held & w_held & ~s_axi_bvalid & ~busy; // [R27]
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;

  // write address decode
  always_comb begin
    wr_draw = 1'b0;
    wr_setup = 1'b0;
    wr_addr = 1'b0;
    wr_cont = 1'b0;
    wr_ok = 1'b1;
    if (in_bank(aw_addr_q, `SLS_OFF_SLOPE_DRAW)) begin
      wr_draw = do_write;
    end else if (in_bank(aw_addr_q, `SLS_OFF_SLOPE_SETUP)) begin
      wr_setup = do_write;
    end else if (aw_addr_q == `SLS_OFF_DRAW_ADDR) begin
      wr_addr = do_write;
    end else if (aw_addr_q == `SLS_OFF_CONTINUE) begin
      wr_cont = do_write;
    end else if (aw_addr_q > `SLS_OFF_PARAM3) begin
      wr_ok = 1'b0; // status and working registers are read only
    end
  end

  // address and data channels are caught separately, in either order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `SLS_RESP_OKAY : `SLS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      draw_address_reg <= 32'h0000_0000;
      pattern_data_reg <= 32'h0000_0000;
      bitmap_pitch_reg <= 32'h0000_0000;
      draw_mode_reg <= `SLS_MODE_RESET;
      raster_operation_reg <= `SLS_ROP_RESET;
      foreground_colour_reg <= 32'h0000_0000;
      background_colour_reg <= 32'h0000_0000;
    end else if (do_write) begin
      if (aw_addr_q == `SLS_OFF_DRAW_ADDR) begin
        draw_address_reg <= merge(draw_address_reg, w_data_q, w_strb_q);
      end else if (aw_addr_q == `SLS_OFF_PATTERN) begin
        pattern_data_reg <= merge(pattern_data_reg, w_data_q, w_strb_q);
      end else if (aw_addr_q == `SLS_OFF_PITCH) begin
        bitmap_pitch_reg <= merge(bitmap_pitch_reg, w_data_q, w_strb_q);
      end else if (aw_addr_q == `SLS_OFF_MODE) begin
        draw_mode_reg <= merge(draw_mode_reg, w_data_q, w_strb_q);
      end else if (aw_addr_q == `SLS_OFF_ROP) begin
        raster_operation_reg <= merge(raster_operation_reg, w_data_q, w_strb_q);
      end else if (aw_addr_q == `SLS_OFF_FG) begin
        foreground_colour_reg <= merge(foreground_colour_reg, w_data_q, w_strb_q);
      end else if (aw_addr_q == `SLS_OFF_BG) begin
        background_colour_reg <= merge(background_colour_reg, w_data_q, w_strb_q);
      end
    end
  end

  // stepping parameters: loaded by either slope bank, or written directly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stepper_param_one_reg <= 32'h0000_0000;
      stepper_param_two_reg <= 32'h0000_0000;
      stepper_param_three_reg <= 32'h0000_0000;
    end else if (wr_draw || wr_setup) begin // [R1] [R14]
      stepper_param_one_reg <= {su_ai1, su_ei1}; // [R12]
      stepper_param_two_reg <= {su_ai2, su_ei2}; // [R12]
      stepper_param_three_reg <= {su_ierr, 12'h000, su_len}; // [R12]
    end else if (do_write) begin
      if (aw_addr_q == `SLS_OFF_PARAM1) begin
        stepper_param_one_reg <= merge(stepper_param_one_reg, w_data_q, w_strb_q);
      end else if (aw_addr_q == `SLS_OFF_PARAM2) begin
        stepper_param_two_reg <= merge(stepper_param_two_reg, w_data_q, w_strb_q);
      end else if (aw_addr_q == `SLS_OFF_PARAM3) begin
        stepper_param_three_reg <= merge(stepper_param_three_reg, w_data_q, w_strb_q);
      end
    end
  end

  // reload flags: set by writes, cleared when a segment starts; writes are held off then
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slope_dirty <= 1'b0;
      addr_dirty <= 1'b0;
    end else begin
      if (wr_draw || wr_setup) begin
        slope_dirty <= 1'b1; // [R16]
      end else if (start_pend) begin
        slope_dirty <= 1'b0;
      end
      if (wr_addr) begin
        addr_dirty <= 1'b1; // [R17]
      end else if (start_pend) begin
        addr_dirty <= 1'b0;
      end
    end
  end

  // segment trigger: a draw slope uses the pattern register, continue carries its own
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_pend <= 1'b0;
      start_pattern <= 16'h0000;
    end else if (wr_draw) begin
      start_pend <= 1'b1; // [R1] [R15]
      start_pattern <= pattern_data_reg[15:0]; // [R3]
    end else if (wr_cont) begin
      start_pend <= 1'b1; // [R19]
      start_pattern <= w_data_q[15:0]; // [R19]
    end else begin
      start_pend <= 1'b0;
    end
  end

  // working set as seen by a starting segment
  always_comb begin
    next_len = slope_dirty ? {1'b0, stepper_param_three_reg[3:0]} : w_len; // [R16]
    next_err = slope_dirty ? stepper_param_three_reg[31:16] : w_err; // [R16]
    next_addr = addr_dirty ? draw_address_reg : w_addr; // [R17] [R21]
  end

  // one stepping move: negative error steps the major axis only
  assign step = pix_valid & pix_ready;
  always_comb begin
    if (w_err[15]) begin // [R25]
      step_addr = w_addr + {{16{stepper_param_one_reg[31]}}, stepper_param_one_reg[31:16]};
      step_err = w_err + stepper_param_one_reg[15:0];
    end else begin
      step_addr = w_addr + {{16{stepper_param_two_reg[31]}}, stepper_param_two_reg[31:16]};
      step_err = w_err - stepper_param_two_reg[15:0];
    end
  end

  // segment sequencer and working set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= sls_pkg::sls_idle;
      w_addr <= 32'h0000_0000;
      w_err <= 16'h0000;
      w_len <= `SLS_SEG_FULL;
      w_pattern <= 16'h0000;
    end else begin
      case (state)
        sls_pkg::sls_idle: begin
          if (start_pend) begin // [R15]
            w_addr <= next_addr;
            w_err <= next_err;
            w_pattern <= start_pattern;
            if (next_len == 5'h00) begin
              w_len <= `SLS_SEG_FULL; // empty segment ends at once
            end else begin
              w_len <= next_len;
              state <= sls_pkg::sls_pixel;
            end
          end
        end
        sls_pkg::sls_pixel: begin
          if (step) begin
            w_addr <= step_addr; // [R25] [R18]
            w_err <= step_err; // [R25] [R18]
            w_pattern <= {1'b0, w_pattern[15:1]};
            if (w_len == 5'h01) begin // [R26]
              w_len <= `SLS_SEG_FULL; // [R18]
              state <= sls_pkg::sls_idle;
            end else begin
              w_len <= w_len - 5'h01; // [R26]
            end
          end
        end
        default: state <= sls_pkg::sls_idle;
      endcase
    end
  end

  // per-segment snapshot of colours and raster controls
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_fg <= 32'h0000_0000;
      s_bg <= 32'h0000_0000;
      pix_rop <= 4'h0;
      pix_byte_mask <= 4'h0;
      pix_bitmap <= 3'h0;
    end else if (start_pend && state == sls_pkg::sls_idle) begin
      s_fg <= foreground_colour_reg; // [R20]
      s_bg <= background_colour_reg; // [R20]
      pix_rop <= raster_operation_reg[3:0]; // [R24]
      pix_byte_mask <= raster_operation_reg[19:16]; // [R24]
      pix_bitmap <= raster_operation_reg[10:8];
    end
  end

  // pixel colour follows the low pattern bit, lsb first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pix_colour <= 32'h0000_0000;
    end else if (start_pend && state == sls_pkg::sls_idle) begin
      pix_colour <= start_pattern[0] ? foreground_colour_reg : background_colour_reg; // [R23]
    end else if (step) begin
      pix_colour <= w_pattern[1] ? s_fg : s_bg; // [R23]
    end
  end

  assign pix_valid = (state == sls_pkg::sls_pixel);
  assign pix_addr = w_addr;

  // read decode on the word-aligned address
  assign raddr = {s_axi_araddr[7:2], 2'h0};
  always_comb begin
    read_mux = 32'h0000_0000;
    read_ok = 1'b1;
    if (in_bank(raddr, `SLS_OFF_SLOPE_DRAW) || in_bank(raddr, `SLS_OFF_SLOPE_SETUP)) begin
      read_mux = 32'h0000_0000; // slope banks are write only
    end else if (raddr == `SLS_OFF_DRAW_ADDR) begin
      read_mux = draw_address_reg;
    end else if (raddr == `SLS_OFF_PATTERN) begin
      read_mux = pattern_data_reg;
    end else if (raddr == `SLS_OFF_CONTINUE) begin
      read_mux = {16'h0000, start_pattern};
    end else if (raddr == `SLS_OFF_PITCH) begin
      read_mux = bitmap_pitch_reg;
    end else if (raddr == `SLS_OFF_MODE) begin
      read_mux = draw_mode_reg;
    end else if (raddr == `SLS_OFF_ROP) begin
      read_mux = raster_operation_reg;
    end else if (raddr == `SLS_OFF_FG) begin
      read_mux = foreground_colour_reg;
    end else if (raddr == `SLS_OFF_BG) begin
      read_mux = background_colour_reg;
    end else if (raddr == `SLS_OFF_PARAM1) begin
      read_mux = stepper_param_one_reg; // [R12]
    end else if (raddr == `SLS_OFF_PARAM2) begin
      read_mux = stepper_param_two_reg; // [R12]
    end else if (raddr == `SLS_OFF_PARAM3) begin
      read_mux = stepper_param_three_reg; // [R12]
    end else if (raddr == `SLS_OFF_STATUS) begin
      read_mux = {29'h0000_0000, addr_dirty, slope_dirty, busy};
    end else if (raddr == `SLS_OFF_WORK_ADDR) begin
      read_mux = w_addr;
    end else if (raddr == `SLS_OFF_WORK_ERR) begin
      read_mux = {w_err, 11'h000, w_len};
    end else begin
      read_ok = 1'b0;
    end
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SLS_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_mux;
      s_axi_rresp <= read_ok ? `SLS_RESP_OKAY : `SLS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : sls_engine

// ==== sls_engine_props.sv ====
// sls_engine_props.sv: port-level checks on the line setup engine
module sls_engine_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [31:0] pix_addr,
  input wire logic [31:0] pix_colour,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] aw_a;
  logic [4:0] npix;
  // last taken write address, so a write answer can be tied to its register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_a <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_a <= s_axi_awaddr;
    end
  end
  // pixels taken in the running segment; busy always drops between segments
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      npix <= 5'h00;
    end else if (!busy) begin
      npix <= 5'h00;
    end else if (pix_valid && pix_ready) begin
      npix <= npix + 5'h01;
    end
  end
  pix_hold_a: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_addr)
    && $stable(pix_colour)) else $error("pixel request changed before acceptance");
  pix_in_seg_a: assert property (pix_valid |-> busy)
    else $error("pixel offered outside a segment");
  seg_max_a: assert property (npix <= 5'h10)
    else $error("segment drew more than sixteen pixels");
  draw_start_a: assert property ($rose(s_axi_bvalid) && aw_a < 8'h20 |-> ##[0:1] busy)
    else $error("draw slope write did not start a segment");
  setup_quiet_a: assert property ($rose(s_axi_bvalid) && aw_a >= 8'h20 && aw_a < 8'h40
    |-> !busy [*4]) else $error("setup-only slope write started drawing");
  cont_start_a: assert property ($rose(s_axi_bvalid) && aw_a == 8'h48 |-> ##[0:1] busy)
    else $error("continue write did not start a segment");
  hold_off_a: assert property ($rose(s_axi_bvalid) |-> !$past(busy))
    else $error("write executed while a segment ran");
  read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  cover property (pix_valid && !pix_ready ##1 pix_valid && pix_ready);
  cover property ($rose(s_axi_bvalid) && aw_a == 8'h48);
  cover property (npix == 5'h10);
endmodule : sls_engine_props

bind sls_engine sls_engine_props u_props (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pix_valid,
  .pix_ready, .pix_addr, .pix_colour, .busy);

// ==== sls_engine_tb_top.sv ====
// sls_engine_tb_top.sv: self-checking bench of the line setup engine
module sls_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic pix_valid, pix_ready, busy, stall, sd, ad;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, pix_addr, pix_colour, wa;
  logic [3:0] s_axi_wstrb, pix_rop, pix_byte_mask, ln;
  logic [2:0] pix_bitmap;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // reference copies: plain registers by word index, setup terms, working set
  logic [31:0] rg[64];
  logic [15:0] ai1, ai2, ei1, ei2, ie, we;
  logic [4:0] wl;
  logic [74:0] pq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int bad_count, comparisons, seed;
  sls_engine dut (.*);
  sls_pix_mem u_mem (.clk, .arst_n, .pix_valid, .pix_ready, .stall);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [79:0] g, input logic [79:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task test_done;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // both channels offered together, each dropped when taken; bready held to the answer
  task wr(input logic [7:0] a, input logic [31:0] d);
    bq.push_back(a >= 8'h6C ? 2'h2 : 2'h0);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd
  // expected pixels of one segment, then the working set left at the next pixel
  task seg(input logic [15:0] p);
    if (sd) begin
      wl = {1'b0, ln};
      we = ie;
    end
    if (ad) wa = rg[16];
    sd = 1'b0;
    ad = 1'b0;
    for (int i = 0; i < wl; i++) begin
      pq.push_back({wa, p[i] ? rg[22] : rg[23], rg[21][3:0], rg[21][19:16], rg[21][10:8]});
      if ($signed(we) < 0) begin
        wa = wa + {{16{ai1[15]}}, ai1};
        we = we + ei1;
      end else begin
        wa = wa + {{16{ai2[15]}}, ai2};
        we = we - ei2;
      end
    end
    wl = 5'h10;
  endtask : seg
  // model update, then the bus write; pixels are noted before they can appear
  task op(input logic [7:0] a, input logic [31:0] d);
    logic rm, b;
    logic [15:0] dy, dx, mj, mn, am, an, s, pb;
    dy = d[31:16];
    dx = d[15:0];
    if (a < 8'h40) begin
      rm = dx >= dy;
      mj = rm ? dx : dy;
      mn = rm ? dy : dx;
      pb = 16'h0001 << (rg[20][1] ? 2 : rg[20][0]);
      am = rm ? pb : rg[19][15:0];
      an = rm ? rg[19][15:0] : pb;
      b = rg[20][4] ? (rm ? dy != 0 : dx == 0) : mj != 0;
      ln = mj[3:0] + {3'h0, rg[20][15]};
      ei1 = mn;
      ei2 = mj + ~mn + 16'h0001;
      s = (mn << 1) + ~mj + {15'h0, b};
      ie = {s[15], s[15:1]};
      ai1 = mj != 0 ? am : ~am + 16'h0001;
      ai2 = (mn != 0 ? an : ~an + 16'h0001) + ai1;
      sd = 1'b1;
      if (a < 8'h20) seg(rg[17][15:0]);
    end
    if (a >= 8'h40 && a < 8'h6C) rg[a[7:2]] = d;
    if (a == 8'h40) ad = 1'b1;
    if (a == 8'h48) seg(d[15:0]);
    wr(a, d);
  endtask : op
  // stored terms, then the working set once the segment has drained
  task chkp;
    rd(8'h60, {2'h0, ai1, ei1});
    rd(8'h64, {2'h0, ai2, ei2});
    rd(8'h68, {2'h0, ie, 12'h000, ln});
    for (int k = 0; k < 3000 && (busy !== 1'b0 || pq.size() != 0); k++) @(posedge clk);
    chk({busy, pq.size() != 0}, 2'h0);
    rd(8'h74, {2'h0, we, 11'h000, wl});
    rd(8'h70, {2'h0, wa});
  endtask : chkp
  // results are taken off the queues in the order they appear
  always @(posedge clk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1)
      chk({pix_addr, pix_colour, pix_rop, pix_byte_mask, pix_bitmap}, pq.pop_front());
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk(s_axi_bresp, bq.pop_front());
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    test_done;
  end
  initial begin
    logic [31:0] d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stall} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wa, we, ie, ln, sd, ad} = '0;
    s_axi_wstrb = 4'hF;
    arst_n = 1'b0;
    seed = 32'h11d12a54;
    wl = 5'h10;
    foreach (rg[i]) rg[i] = 32'h0;
    rg[21] = 32'h000F_0003;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h50, {2'h0, rg[20]});
    rd(8'h54, {2'h0, rg[21]});
    rd(8'h78, {2'h2, 32'h0});
    wr(8'h6C, 32'hFFFF_FFFF);
    $display("test reset done");
    op(8'h4C, 32'h0000_0100);
    op(8'h58, 32'h00AA_0011);
    op(8'h5C, 32'h0055_0022);
    stall <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      op(8'h40, 32'h0000_8000 | (32'($random(seed)) & 32'h0000_0FFF));
      op(8'h44, $random(seed));
      d = $random(seed) & 32'h001F_001F;
      if (d == 0) d = 32'h0000_0001;
      op(8'(n * 4), d);
      chkp;
    end
    $display("test octants done");
    op(8'h48, $random(seed));
    op(8'h58, 32'h00C0_FFEE);
    op(8'h48, $random(seed));
    chkp;
    $display("test extend done");
    stall <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      op(8'h50, {16'h0, m[1], 10'h0, m[0], 2'h0, 2'(m)});
      op(8'h44, $random(seed));
      d = ($random(seed) & 32'h000F_001F) | 32'h0000_0001;
      op(8'(m * 8 + 4), d);
      chkp;
    end
    op(8'h50, 32'h0);
    op(8'h04, 32'h0003_0013);
    chkp;
    $display("test polyline done");
    op(8'h2C, 32'h0005_0009);
    chkp;
    $display("test setup only done");
    test_done;
  end
endmodule : sls_engine_tb_top

// ==== sls_pix_mem.sv ====
// sls_pix_mem.sv: memory controller stand-in that takes pixel writes, stalling when asked
module sls_pix_mem (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pix_valid,
  input wire logic stall,
  output logic pix_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lfsr;
  // pattern moves only under traffic, so stall runs vary from pixel to pixel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lfsr <= 8'hA5;
    end else if (pix_valid) begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end
  // ready may stand before valid; raster op and byte mask are not applied by this stand-in
  assign pix_ready = !stall || lfsr[0];
endmodule : sls_pix_mem

// ==== sls_pkg.sv ====
// sls_pkg.sv: types shared by the line setup engine
package sls_pkg;
  typedef enum logic [0:0] {
    sls_idle,
    sls_pixel
  } sls_state_e;
endpackage : sls_pkg

// ==== sls_setup.sv ====
// sls_setup.sv: combinational computation of the stepping terms from rise and run
module sls_setup (
  input wire logic [15:0] rise,
  input wire logic [15:0] run,
  input wire logic [15:0] pixel_bytes,
  input wire logic [15:0] pitch,
  input wire logic cap_ends,
  input wire logic strict_env,
  output logic [15:0] addr_inc_one,
  output logic [15:0] err_inc_one,
  output logic [15:0] addr_inc_two,
  output logic [15:0] err_inc_two,
  output logic [15:0] init_err,
  output logic [3:0] seg_len
);
  // two's-complement negation, used for both address steps
  function automatic logic [15:0] neg16(input logic [15:0] v);
    neg16 = ~v + 16'h0001;
  endfunction : neg16

  logic run_is_major;
  logic run_nz;
  logic rise_nz;
  logic major_nz;
  logic minor_nz;
  logic bias;
  logic [15:0] dmajor;
  logic [15:0] dminor;
  logic [15:0] amajor;
  logic [15:0] aminor;
  logic [17:0] err_sum;
  logic [15:0] len_sum;

  // axis choice and nonzero flags
  assign run_is_major = (run >= rise); // [R4]
  assign run_nz = (run != 16'h0000);
  assign rise_nz = (rise != 16'h0000);
  assign dmajor = run_is_major ? run : rise; // [R4]
  assign dminor = run_is_major ? rise : run;
  assign major_nz = run_is_major ? run_nz : rise_nz;
  assign minor_nz = run_is_major ? rise_nz : run_nz;
  assign amajor = run_is_major ? pixel_bytes : pitch; // [R5]
  assign aminor = run_is_major ? pitch : pixel_bytes; // [R5]
  // strict quantisation breaks ties toward the upper or left pixel
  assign bias = strict_env ? (run_is_major ? rise_nz : ~run_nz) : major_nz; // [R6]

  // length wraps at 16 on purpose: the segment is never longer than one mask
  assign len_sum = dmajor + {15'h0000, cap_ends};
  assign seg_len = len_sum[3:0]; // [R7]
  assign err_inc_one = dminor; // [R8]
  assign err_inc_two = dmajor + ~dminor + 16'h0001; // [R8]
  assign err_sum = {1'b0, dminor, 1'b0} + {2'h3, ~dmajor} + {17'h00000, bias};
  assign init_err = err_sum[16:1]; // [R9]
  assign addr_inc_one = major_nz ? amajor : neg16(amajor); // [R10]
  assign addr_inc_two = (minor_nz ? aminor : neg16(aminor)) + addr_inc_one; // [R11]
endmodule : sls_setup
